/* File: rtcsa_pkg.sv */
// Shared types and constants for the clock serial slave access block
package rtcsa_pkg;

   // ==========================================
   // Addressing
   // ==========================================
   // 7-bit bus address, D0h when written with a cleared direction bit
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam int NBYTES = 8;
   localparam int IDX_W = 3;

   // Byte order as the pointer walks through them
   localparam logic [2:0] IDX_SEC = 3'h0;
   localparam logic [2:0] IDX_MIN = 3'h1;
   localparam logic [2:0] IDX_CENT_HOUR = 3'h2;
   localparam logic [2:0] IDX_DAY = 3'h3;
   localparam logic [2:0] IDX_DATE = 3'h4;
   localparam logic [2:0] IDX_MONTH = 3'h5;
   localparam logic [2:0] IDX_YEAR = 3'h6;
   localparam logic [2:0] IDX_CTRL = 3'h7;

   // ==========================================
   // Reset values and framing counts
   // ==========================================
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] PTR_RST = 3'h0;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] CNT_RST = 4'h0;
   // Link side synchroniser reset: scl, sda idle high, others low
   localparam logic [3:0] LINK_SYNC_RST = 4'hC;
   localparam logic [1:0] SYS_SYNC_RST = 2'h0;

   // ==========================================
   // Types
   // ==========================================
   typedef enum logic [2:0] {
      LS_IDLE, LS_ADDR, LS_WORD, LS_WDATA, LS_ACKO, LS_TX, LS_ACKI,
      LS_IGNORE
   } rtcsa_lstate_t;

   // Eight BCD bytes, index 0 is seconds
   typedef logic [NBYTES-1:0][7:0] rtcsa_bytes_t;

   // One access carried from the link to the store
   typedef struct packed {
      logic wr;
      logic [IDX_W-1:0] idx;
      logic [7:0] data;
   } rtcsa_xfer_t;

   // Load port for the timekeeping logic
   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
      logic [7:0] data;
   } rtcsa_upd_t;

endpackage : rtcsa_pkg

/* File: rtcsa_sync.sv */
// Two-flop synchroniser for a group of levels
`timescale 1ns/100ps
module rtcsa_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rtcsa_sync_st_t;

   rtcsa_sync_st_t s_r;
   rtcsa_sync_st_t s_nxt;

   // First stage feeds only the second
   always_comb begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= {RST, RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;
endmodule : rtcsa_sync

/* File: rtcsa_cond.sv */
// Bus condition detector for synchronised clock and data lines
`timescale 1ns/100ps
module rtcsa_cond (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Synchronised lines
   input wire logic scl,
   input wire logic sda,
   // Conditions, one cycle each
   output logic start,
   output logic stop,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic scl_p;
      logic sda_p;
   } rtcsa_cond_st_t;

   rtcsa_cond_st_t c_r;
   rtcsa_cond_st_t c_nxt;

   always_comb begin
      c_nxt.scl_p = scl;
      c_nxt.sda_p = sda;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c_r <= 2'h3;
      end else begin
         c_r <= c_nxt;
      end
   end

   // Data edges with clock high both cycles are control conditions
   assign start = c_r.scl_p & scl & c_r.sda_p & ~sda;
   assign stop = c_r.scl_p & scl & ~c_r.sda_p & sda;
   assign rise = ~c_r.scl_p & scl;
   assign fall = c_r.scl_p & ~scl;
endmodule : rtcsa_cond

/* File: rtcsa_top.sv */
// Serial slave access to the eight clock and calendar bytes
`timescale 1ns/100ps

// Notes on behaviour
// - Access begins with START plus address; answer only own address 68h (D0h write, D1h read).
// - Eight bytes in order seconds, minutes, century/hours ... control.
// - Pointer advances after every written data byte and every acknowledged read byte.
// - Clock and calendar contents held as BCD bytes.
// - Supply below threshold aborts access and clears the pointer.
// - Below threshold all bus inputs are ignored; nothing is written.
// - Supply back above threshold resumes recognising bus inputs.
// - Data stable while clock high; changes then are control conditions.
// - Bus idle when data and clock are both high.
// - Data falling while clock high is a START.
// - Data rising while clock high is a STOP, ending transfer.
// - One clock pulse per bit, sampled while clock high.
// - Any number of bytes between START and STOP.
// - Each byte followed by one acknowledge bit from the receiver.
// - As receiver, acknowledge address, word address and every data byte.
// - Acknowledge held low through the whole acknowledge clock high.
// - After a withheld acknowledge, release data high for the STOP.
// - On reads the pointer advances only on a master acknowledge.
// - Byte after address with write direction loads the pointer.
// - Read without word address starts at the current pointer.
module rtcsa_top (
   // System clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link clock and bus pins
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Supply monitor
   input wire logic below_backup_switchover_threshold,
   // Timekeeping side
   input wire rtcsa_pkg::rtcsa_upd_t upd,
   output rtcsa_pkg::rtcsa_bytes_t clk_bytes,
   output logic bus_wr_pulse
);
   import rtcsa_pkg::*;

   // ==========================================
   // State
   // ==========================================
   typedef struct packed {
      rtcsa_lstate_t st;
      rtcsa_lstate_t prev;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [IDX_W-1:0] ptr;
      logic rw;
      logic acked;
      logic oe;
      logic sdo;
      logic req_tgl;
      logic ack_seen;
      rtcsa_xfer_t xfer;
   } rtcsa_link_st_t;

   typedef struct packed {
      rtcsa_bytes_t mem;
      logic [7:0] rdata;
      logic ack_tgl;
      logic req_last;
      logic wr_pulse;
   } rtcsa_sys_st_t;

   rtcsa_link_st_t l_r;
   rtcsa_link_st_t l_nxt;
   rtcsa_sys_st_t s_r;
   rtcsa_sys_st_t s_nxt;

   logic lrst_n, scl_s, sda_s, low_l;
   logic ack_s, req_s, low_s;
   logic start, stop, rise, fall;

   // ==========================================
   // Crossings
   // ==========================================
   rtcsa_sync #(.W(1), .RST(1'b0)) u_lrst (
      .clk(link_clk),
      .rst_n(rstn),
      .d(1'b1),
      .q(lrst_n)
   );

   rtcsa_sync #(.W(4), .RST(LINK_SYNC_RST)) u_lsync (
      .clk(link_clk),
      .rst_n(lrst_n),
      .d({scl_i, sda_i, below_backup_switchover_threshold, s_r.ack_tgl}),
      .q({scl_s, sda_s, low_l, ack_s})
   );

   rtcsa_sync #(.W(2), .RST(SYS_SYNC_RST)) u_ssync (
      .clk(clock),
      .rst_n(rstn),
      .d({l_r.req_tgl, below_backup_switchover_threshold}),
      .q({req_s, low_s})
   );

   rtcsa_cond u_cond (
      .clk(link_clk),
      .rst_n(lrst_n),
      .scl(scl_s),
      .sda(sda_s),
      .start(start),
      .stop(stop),
      .rise(rise),
      .fall(fall)
   );

   // ==========================================
   // Link engine
   // ==========================================
   always_comb begin
      l_nxt = l_r;
      l_nxt.sdo = 1'b0;
      l_nxt.ack_seen = ack_s;
      if (low_l) begin
         // Deselected: abort, clear pointer, listen to nothing
         l_nxt.st = LS_IDLE;
         l_nxt.ptr = PTR_RST;
         l_nxt.oe = 1'b0;
         l_nxt.cnt = CNT_RST;
      end else if (start) begin
         // Also a repeated start from any state
         l_nxt.st = LS_ADDR;
         l_nxt.cnt = CNT_RST;
         l_nxt.oe = 1'b0;
      end else if (stop) begin
         l_nxt.st = LS_IDLE;
         l_nxt.oe = 1'b0;
      end else begin
         case (l_r.st)
            LS_ADDR, LS_WORD, LS_WDATA: begin
               if (rise && l_r.cnt != BITS_PER_BYTE) begin
                  l_nxt.sh = {l_r.sh[6:0], sda_s};
                  l_nxt.cnt = l_r.cnt + 4'h1;
               end else if (fall && l_r.cnt == BITS_PER_BYTE) begin
                  l_nxt.cnt = CNT_RST;
                  l_nxt.prev = l_r.st;
                  l_nxt.oe = 1'b1;
                  l_nxt.st = LS_ACKO;
                  if (l_r.st == LS_ADDR) begin
                     if (l_r.sh[7:1] != SLAVE_ADDR) begin
                        l_nxt.oe = 1'b0;
                        l_nxt.st = LS_IGNORE;
                     end else begin
                        l_nxt.rw = l_r.sh[0];
                        if (l_r.sh[0]) begin
                           // Fetch from the held pointer
                           l_nxt.xfer = '{1'b0, l_r.ptr, 8'h00};
                           l_nxt.req_tgl = ~l_r.req_tgl;
                        end
                     end
                  end else if (l_r.st == LS_WORD) begin
                     l_nxt.ptr = l_r.sh[IDX_W-1:0];
                  end else begin
                     l_nxt.xfer = '{1'b1, l_r.ptr, l_r.sh};
                     l_nxt.req_tgl = ~l_r.req_tgl;
                     l_nxt.ptr = l_r.ptr + 3'h1;
                  end
               end
            end
            LS_ACKO: begin
               if (fall) begin
                  // Release after the acknowledge clock low edge
                  l_nxt.oe = 1'b0;
                  l_nxt.cnt = CNT_RST;
                  if (l_r.prev == LS_ADDR && l_r.rw) begin
                     l_nxt.sh = s_r.rdata;
                     l_nxt.oe = ~s_r.rdata[7];
                     l_nxt.cnt = 4'h1;
                     l_nxt.st = LS_TX;
                  end else if (l_r.prev == LS_ADDR) begin
                     l_nxt.st = LS_WORD;
                  end else begin
                     l_nxt.st = LS_WDATA;
                  end
               end
            end
            LS_TX: begin
               if (fall) begin
                  if (l_r.cnt == BITS_PER_BYTE) begin
                     l_nxt.oe = 1'b0;
                     l_nxt.st = LS_ACKI;
                  end else begin
                     l_nxt.oe = ~l_r.sh[6];
                     l_nxt.sh = {l_r.sh[6:0], 1'b0};
                     l_nxt.cnt = l_r.cnt + 4'h1;
                  end
               end
            end
            LS_ACKI: begin
               if (rise) begin
                  l_nxt.acked = ~sda_s;
                  if (!sda_s) begin
                     l_nxt.ptr = l_r.ptr + 3'h1;
                     l_nxt.xfer = '{1'b0, l_r.ptr + 3'h1, 8'h00};
                     l_nxt.req_tgl = ~l_r.req_tgl;
                  end
               end else if (fall) begin
                  if (l_r.acked) begin
                     l_nxt.sh = s_r.rdata;
                     l_nxt.oe = ~s_r.rdata[7];
                     l_nxt.cnt = 4'h1;
                     l_nxt.st = LS_TX;
                  end else begin
                     l_nxt.st = LS_IGNORE;
                  end
               end
            end
            default: l_nxt.st = l_r.st;
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   // ==========================================
   // Byte store
   // ==========================================
   always_comb begin
      s_nxt = s_r;
      s_nxt.wr_pulse = 1'b0;
      if (upd.valid) begin
         s_nxt.mem[upd.idx] = upd.data;
      end
      if (req_s != s_r.req_last) begin
         s_nxt.req_last = req_s;
         s_nxt.ack_tgl = ~s_r.ack_tgl;
         if (!l_r.xfer.wr) begin
            s_nxt.rdata = s_r.mem[l_r.xfer.idx];
         end else if (!low_s) begin
            // Bus write wins over a timekeeping load
            s_nxt.mem[l_r.xfer.idx] = l_r.xfer.data;
            s_nxt.wr_pulse = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sda_o = l_r.sdo;
   assign sda_oe = l_r.oe;
   assign clk_bytes = s_r.mem;
   assign bus_wr_pulse = s_r.wr_pulse;

   // ==========================================
   // Checks
   // ==========================================
   sequence s_addr_done;
      l_r.st == LS_ADDR && l_r.cnt == BITS_PER_BYTE && fall && !low_l;
   endsequence

   sequence s_master_ack;
      l_r.st == LS_ACKI && rise && !sda_s && !low_l;
   endsequence

   property p_addr_match;
      @(posedge link_clk) disable iff (!lrst_n)
      s_addr_done and (l_r.sh[7:1] == SLAVE_ADDR)
         |=> l_r.oe && l_r.st == LS_ACKO;
   endproperty
   a_addr_match: assert property (p_addr_match)
      else $error("own address not acknowledged");

   property p_addr_miss;
      @(posedge link_clk) disable iff (!lrst_n)
      s_addr_done and (l_r.sh[7:1] != SLAVE_ADDR)
         |=> !l_r.oe && l_r.st == LS_IGNORE;
   endproperty
   a_addr_miss: assert property (p_addr_miss)
      else $error("foreign address acknowledged");

   property p_start;
      @(posedge link_clk) disable iff (!lrst_n)
      start && !low_l |=> l_r.st == LS_ADDR && l_r.cnt == CNT_RST;
   endproperty
   a_start: assert property (p_start)
      else $error("start not taken");

   property p_stop;
      @(posedge link_clk) disable iff (!lrst_n)
      stop && !low_l |=> l_r.st == LS_IDLE && !l_r.oe;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not end transfer");

   property p_low_abort;
      @(posedge link_clk) disable iff (!lrst_n)
      low_l |=> l_r.ptr == PTR_RST && !l_r.oe && l_r.st == LS_IDLE;
   endproperty
   a_low_abort: assert property (p_low_abort)
      else $error("deselect did not abort");

   property p_low_ignore;
      @(posedge link_clk) disable iff (!lrst_n)
      low_l && $past(low_l) |-> $stable(l_r.req_tgl);
   endproperty
   a_low_ignore: assert property (p_low_ignore)
      else $error("access issued while deselected");

   property p_ack_hold;
      @(posedge link_clk) disable iff (!lrst_n)
      l_r.st == LS_ACKO && l_r.oe && !low_l && !start && !stop && !fall
         |=> l_r.oe;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("acknowledge released early");

   property p_read_inc;
      @(posedge link_clk) disable iff (!lrst_n)
      s_master_ack |=> l_r.ptr == $past(l_r.ptr) + 3'h1;
   endproperty
   a_read_inc: assert property (p_read_inc)
      else $error("pointer not advanced on acknowledge");

   property p_nack_release;
      @(posedge link_clk) disable iff (!lrst_n)
      l_r.st == LS_ACKI && rise && sda_s && !low_l
         |=> !l_r.oe ##0 $stable(l_r.ptr);
   endproperty
   a_nack_release: assert property (p_nack_release)
      else $error("line held after missing acknowledge");

   property p_word;
      @(posedge link_clk) disable iff (!lrst_n)
      l_r.st == LS_WORD && l_r.cnt == BITS_PER_BYTE && fall && !low_l
         |=> l_r.ptr == $past(l_r.sh[IDX_W-1:0]);
   endproperty
   a_word: assert property (p_word)
      else $error("word address not loaded");

   // Read data is only taken once the store has answered the request
   property p_rd_ready;
      @(posedge link_clk) disable iff (!lrst_n)
      fall && !low_l && (l_r.st == LS_ACKI ? l_r.acked
         : l_r.st == LS_ACKO && l_r.prev == LS_ADDR && l_r.rw)
         |-> l_r.ack_seen == l_r.req_tgl;
   endproperty
   a_rd_ready: assert property (p_rd_ready)
      else $error("read data taken before the store answered");

   property p_store;
      @(posedge clock) disable iff (!rstn)
      req_s != s_r.req_last && l_r.xfer.wr && !low_s
         |=> bus_wr_pulse && clk_bytes[$past(l_r.xfer.idx)]
            == $past(l_r.xfer.data);
   endproperty
   a_store: assert property (p_store)
      else $error("bus write not stored");

endmodule : rtcsa_top

/* File: rtcsa_master.sv */
// Behavioural two-wire bus master that drives the link from the far side
`timescale 1ns/100ps
module rtcsa_master (
   // Bus lines
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   localparam int T = 150;

   initial begin
      scl = 1'h1;
      sda_pull = 1'h0;
   end

   // ==========================================
   // Bit level
   // ==========================================
   // Data moves only while the clock is low, one pulse per bit
   task automatic bit_out(input logic b);
      #T sda_pull = ~b;
      #T scl = 1'h1;
      #(2*T) scl = 1'h0;
   endtask : bit_out

   task automatic bit_in(output logic b);
      #T sda_pull = 1'h0;
      #T scl = 1'h1;
      #T b = sda;
      #T scl = 1'h0;
   endtask : bit_in

   // ==========================================
   // Conditions
   // ==========================================
   // Called only on an idle bus or as a repeated start
   task automatic start();
      #T sda_pull = 1'h0;
      #T scl = 1'h1;
      #T sda_pull = 1'h1;
      #T scl = 1'h0;
   endtask : start

   task automatic stop();
      #T sda_pull = 1'h1;
      #T scl = 1'h1;
      #T sda_pull = 1'h0;
      #T;
   endtask : stop

   // ==========================================
   // Byte level
   // ==========================================
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      bit_in(s);
      ack = ~s;
   endtask : wr_byte

   // Acknowledge all but the last byte wanted
   task automatic rd_byte(output logic [7:0] d, input logic more);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(~more);
   endtask : rd_byte
endmodule : rtcsa_master

/* File: rtcsa_bench.sv */
// Self-checking bench for the clock serial slave access block
`timescale 1ns/100ps
module rtcsa_bench;
   import rtcsa_pkg::*;
   logic clock, rstn, link_clk, below, sda_o, sda_oe, bus_wr_pulse;
   logic scl, m_pull, sda;
   rtcsa_upd_t upd;
   rtcsa_bytes_t clk_bytes, exp_bytes;
   logic [2:0] ptr;
   logic [31:0] seed_v;
   int fail_count = 0;
   int n_checks = 0;
   int n_wr = 0;

   // Wired data line with pull-up
   assign sda = ~m_pull & (~sda_oe | sda_o);

   rtcsa_top rtcsa_top_inst (.clock(clock), .rstn(rstn),
      .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .below_backup_switchover_threshold(below),
      .upd(upd), .clk_bytes(clk_bytes), .bus_wr_pulse(bus_wr_pulse));
   rtcsa_master rtcsa_master_inst (.scl(scl), .sda_pull(m_pull), .sda(sda));

   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   initial begin
      link_clk = 1'h0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   always @(posedge clock) if (bus_wr_pulse === 1'h1) n_wr++;

   // ==========================================
   // Checking
   // ==========================================
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   function automatic logic [7:0] bcd_rand();
      return {4'($urandom_range(9)), 4'($urandom_range(9))};
   endfunction : bcd_rand

   // ==========================================
   // Sequences
   // ==========================================
   task automatic wr_seq(input logic [7:0] a, input int n);
      logic ack;
      logic [7:0] d;
      int w0;
      w0 = n_wr;
      rtcsa_master_inst.start();
      rtcsa_master_inst.wr_byte({SLAVE_ADDR, 1'h0}, ack);
      check("write addr ack", ack, 1'h1);
      rtcsa_master_inst.wr_byte(a, ack);
      check("word addr ack", ack, 1'h1);
      ptr = a[2:0];
      for (int i = 0; i < n; i++) begin
         d = bcd_rand();
         rtcsa_master_inst.wr_byte(d, ack);
         check("data ack", ack, 1'h1);
         exp_bytes[ptr] = d;
         ptr = ptr + 3'h1;
      end
      rtcsa_master_inst.stop();
      check("write pulses", n_wr - w0, n);
      check("bytes after write", clk_bytes, exp_bytes);
   endtask : wr_seq

   task automatic rd_seq(input logic set, input logic [7:0] a, input int n);
      logic ack;
      logic [7:0] d;
      if (set) begin
         rtcsa_master_inst.start();
         rtcsa_master_inst.wr_byte({SLAVE_ADDR, 1'h0}, ack);
         rtcsa_master_inst.wr_byte(a, ack);
         ptr = a[2:0];
      end
      rtcsa_master_inst.start();
      rtcsa_master_inst.wr_byte({SLAVE_ADDR, 1'h1}, ack);
      check("read addr ack", ack, 1'h1);
      for (int i = 0; i < n; i++) begin
         rtcsa_master_inst.rd_byte(d, i < n - 1);
         check("read data", d, exp_bytes[ptr]);
         if (i < n - 1) ptr = ptr + 3'h1;
      end
      #100;
      check("release after nack", sda_oe, 1'h0);
      check("data out level", sda_o, 1'h0);
      rtcsa_master_inst.stop();
   endtask : rd_seq

   task automatic upd_seq();
      logic [2:0] k;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         k = 3'($urandom);
         d = bcd_rand();
         @(posedge clock);
         #1 upd = '{1'h1, k, d};
         exp_bytes[k] = d;
         @(posedge clock);
         #1 upd.valid = 1'h0;
      end
      check("bytes after load", clk_bytes, exp_bytes);
   endtask : upd_seq

   task automatic bad_addr();
      logic ack;
      logic [6:0] b;
      b = SLAVE_ADDR;
      while (b == SLAVE_ADDR) b = 7'($urandom);
      rtcsa_master_inst.start();
      rtcsa_master_inst.wr_byte({b, 1'($urandom)}, ack);
      check("foreign addr ack", ack, 1'h0);
      rtcsa_master_inst.wr_byte({SLAVE_ADDR, 1'h0}, ack);
      check("ignored byte ack", ack, 1'h0);
      rtcsa_master_inst.stop();
      check("bytes after foreign", clk_bytes, exp_bytes);
   endtask : bad_addr

   task automatic supply_drop();
      logic ack;
      rtcsa_master_inst.start();
      rtcsa_master_inst.wr_byte({SLAVE_ADDR, 1'h0}, ack);
      rtcsa_master_inst.wr_byte(8'h05, ack);
      @(posedge clock);
      #1 below = 1'h1;
      rtcsa_master_inst.wr_byte(8'h59, ack);
      check("ack while low", ack, 1'h0);
      rtcsa_master_inst.stop();
      check("bytes while low", clk_bytes, exp_bytes);
      @(posedge clock);
      #1 below = 1'h0;
      repeat (20) @(posedge clock);
      ptr = 3'h0;
      rd_seq(1'h0, 8'h0, 2);
   endtask : supply_drop

   // ==========================================
   // Main sequence and watchdog
   // ==========================================
   initial begin
      seed_v = $urandom(32'hB152);
      rstn = 1'h0;
      below = 1'h0;
      upd = '0;
      exp_bytes = '0;
      repeat (8) @(posedge clock);
      #1 rstn = 1'h1;
      repeat (4) @(posedge clock);
      check("bytes after reset", clk_bytes, exp_bytes);
      check("oe after reset", sda_oe, 1'h0);
      check("data out level", sda_o, 1'h0);
      wr_seq(8'hF7, 9);
      for (int r = 0; r < 3; r++) begin
         rd_seq(1'h1, 8'($urandom), 1 + $urandom_range(7));
         rd_seq(1'h0, 8'h0, 1 + $urandom_range(2));
         upd_seq();
         wr_seq(8'($urandom), 1 + $urandom_range(8));
      end
      bad_addr();
      supply_drop();
      close_out();
   end

   initial begin
      #900000;
      fail_count++;
      close_out();
   end
endmodule : rtcsa_bench
